// File: rlyal_pkg.sv
`default_nettype none
package rlyal_pkg;
  // ===========================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int MS_CYC_DEF    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;
  localparam int HARD_DLY_MS   = 2000;
  localparam int SOFT_DLY_MS   = 20000;
  localparam int ILK_DLY_MS    = 3000;
  localparam int FB_SETTLE_MS  = 100;
  localparam int DLY_W         = 15;
  localparam int FB_W          = 7;
  // ===========================================
  // register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_ALARM    = 8'h04;
  localparam logic [7:0] REG_STAT     = 8'h08;
  localparam logic [7:0] REG_FLAG     = 8'h0C;
  localparam logic [7:0] REG_GP_DIR   = 8'h10;
  localparam logic [7:0] REG_GP_OUT   = 8'h14;
  localparam logic [7:0] REG_GP_IN    = 8'h18;
  localparam logic [7:0] REG_AO1      = 8'h1C;
  localparam logic [7:0] REG_AO2      = 8'h20;
  localparam logic [7:0] REG_REPORT   = 8'h24;
  localparam logic [7:0] REG_SENS     = 8'h28;
  localparam logic [7:0] REG_LOG_ADDR = 8'h2C;
  localparam logic [7:0] REG_LOG_DATA = 8'h30;
  localparam logic [7:0] REG_LOG_BUMP = 8'h34;
  // ===========================================
  // field positions and widths
  localparam int CTRL_REQ   = 0;
  localparam int CTRL_FBEN  = 2;
  localparam int CTRL_SDCLR = 4;
  localparam int AL_WARN    = 0;
  localparam int AL_SOFT    = 1;
  localparam int AL_HARD    = 2;
  localparam int AL_SERVICE = 3;
  localparam int AL_SENSOR  = 4;
  localparam int AL_W       = 5;
  localparam int FL_FOPEN   = 0;
  localparam int FL_FCLOSED = 2;
  localparam int ST_DRV     = 0;
  localparam int ST_FB      = 2;
  localparam int ST_CONF    = 4;
  localparam int ST_ILKF    = 6;
  localparam int ST_ILKT    = 7;
  localparam int ST_SDPEND  = 8;
  localparam int ST_SDTRIP  = 9;
  localparam int ST_AOMODE  = 10;
  localparam int RP_CAN     = 0;
  localparam int RP_UART    = 1;
  localparam int RP_DIG     = 2;
  localparam int RP_ANA     = 3;
  localparam int AO_W       = 13;
  localparam int SENS_W     = 16;
  localparam int LOG_DEPTH  = 64;
  localparam int LOG_AW     = 6;
  localparam logic [AO_W-1:0] AO_FULL  = 13'h1FFF;
  localparam logic [31:0]     RST_WORD = 32'h0000_0000;
  // ===========================================
  // shutdown sequencer states
  typedef enum logic [1:0] {SD_IDLE, SD_PENDING, SD_TRIPPED} rlyal_sd_e;
endpackage
`default_nettype wire

// File: rlyal_dly_if.sv
`timescale 1ns/10ps
`default_nettype none
// ===========================================
// one delay timer: armed level in, elapsed level out
interface rlyal_dly_if;
  logic arm;
  logic tick;
  logic done;
  modport timer (input arm, input tick, output done);
  modport ctrl  (output arm, output tick, input done);
endinterface
`default_nettype wire

// File: rlyal_delay.sv
`timescale 1ns/10ps
`default_nettype none
// ===========================================
// millisecond delay; done rises between LIMIT_MS and LIMIT_MS+1 ms after arm
module rlyal_delay
  import rlyal_pkg::*;
#(
  parameter int LIMIT_MS = 1
) (
  input  wire logic  clk_sys_in,
  input  wire logic  nrst_in,
  rlyal_dly_if.timer bus
);
  logic [DLY_W-1:0] cnt;

  // counts one extra tick so a tick right after arming never shortens the wait
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
    end else if (!bus.arm) begin
      cnt <= '0;
    end else if (bus.tick && cnt <= DLY_W'(LIMIT_MS)) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign bus.done = bus.arm && (cnt > DLY_W'(LIMIT_MS));
endmodule // rlyal_delay
`default_nettype wire

// File: rlyal_top.sv
// Contract
// - hard shutdown alarm opens both relays after two seconds
// - soft shutdown alarm opens both relays after twenty seconds
// - warning alarm is only flagged, no relay action
// - sensor fault keeps control running, faulty sensor is excluded
// - alarm status reportable on CAN, serial, analog or digital output; only dual-mode output 1 carries it here
// - both relay drivers gated by the one hardware interlock
// - interlock faults on overvoltage, undervoltage, overtemperature or loop fault
// - interlock trigger disables relay drivers after three seconds
// - closed auxiliary contact confirms relay closed
// - command and feedback mismatch raises failed-open or failed-closed alarm
// - six I/O lines; four selectable as input or output
// - two lines are digital outputs, analog by hardware option
// - inputs active low, floating reads off, grounded reads on
// - digital outputs sink load ground when on
// - analog outputs span 0 to 5 V in 1.2 mV steps; the 13-bit code here gives about 0.6 mV steps
// - lifetime per-cell histograms kept in log memory
// - per-cell serial numbers stored for tracking
`timescale 1ns/10ps
`default_nettype none
module rlyal_top
  import rlyal_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  input  wire logic             clk_sys_in,
  input  wire logic             nrst_in,
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  input  wire logic             cell_ov_in,
  input  wire logic             cell_uv_in,
  input  wire logic             cell_ot_in,
  input  wire logic             safety_loop_interlock_ok_in,
  input  wire logic [1:0]       relay_fb_in,
  output logic      [1:0]       relay_drv_out,
  output logic                  relay_enable_out,
  input  wire logic [3:0]       gp_io_line_in,
  output logic      [3:0]       gp_io_line_out,
  output logic      [3:0]       gp_io_line_oe_out,
  input  wire logic [1:0]       analog_mode_in,
  output logic      [1:0]       dual_mode_output_oe_out,
  output logic      [AO_W-1:0]  dual_mode_output_1_code_out,
  output logic      [AO_W-1:0]  dual_mode_output_2_code_out,
  output logic      [AL_W-1:0]  alarm_status_out,
  output logic                  alarm_can_flag_out,
  output logic                  alarm_uart_flag_out,
  output logic      [SENS_W-1:0] sensor_exclude_out
);
  // ===========================================
  // state
  logic [TICK_W-1:0] tick_cnt;
  logic              ms_tick;
  logic [1:0]        relay_req;
  logic [1:0]        fb_en;
  logic [AL_W-1:0]   alarm;
  logic [3:0]        flags;
  logic [3:0]        gp_dir;
  logic [3:0]        gp_out;
  logic [1:0]        dmo_out;
  logic [AO_W-1:0]   ao1;
  logic [AO_W-1:0]   ao2;
  logic [3:0]        report;
  logic [SENS_W-1:0] sens_mask;
  logic [LOG_AW-1:0] log_addr;
  logic [31:0]       log_mem [LOG_DEPTH];
  logic [1:0]        ao_mode;
  logic              strap_taken;
  logic              ilk_fault_q;
  logic              ilk_trip;
  rlyal_sd_e         sd_state;
  logic [1:0]        next_drv;
  logic [3:0]        flag_set;
  logic              sd_expired;
  logic              alarm_any;
  logic              shut_alarm;
  logic [31:0]       rd_mux;
  logic              wr_ctrl;
  rlyal_dly_if       dly [3] ();

  assign wr_ctrl    = reg_wr_in && reg_addr_in == REG_CTRL;
  assign shut_alarm = alarm[AL_SOFT] | alarm[AL_HARD];
  // warning and service faults count for reporting only; sensor fault also gates sensor_exclude_out
  assign alarm_any  = |alarm;

  // ===========================================
  // millisecond enable pulse
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b0;
    end else if (tick_cnt == TICK_W'(MS_CYC - 1)) begin
      tick_cnt <= '0;
      ms_tick  <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ms_tick  <= 1'b0;
    end
  end

  // ===========================================
  // delay timers: hard, soft, interlock
  assign dly[0].arm = sd_state == SD_PENDING && alarm[AL_HARD];
  assign dly[1].arm = sd_state == SD_PENDING && alarm[AL_SOFT];
  assign dly[2].arm = ilk_fault_q;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dly
      localparam int LIM = (gi == 0) ? HARD_DLY_MS :
                           (gi == 1) ? SOFT_DLY_MS : ILK_DLY_MS;
      assign dly[gi].tick = ms_tick;
      rlyal_delay #(.LIMIT_MS(LIM)) u_dly (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .bus        (dly[gi])
      );
    end
  endgenerate
  // whichever timer runs out first wins
  assign sd_expired = dly[0].done | dly[1].done;

  // ===========================================
  // shutdown sequencer
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sd_state <= SD_IDLE;
    end else begin
      case (sd_state)
        SD_IDLE: begin
          if (shut_alarm) begin
            sd_state <= SD_PENDING;
          end
        end
        SD_PENDING: begin
          if (sd_expired) begin
            sd_state <= SD_TRIPPED;
          end else if (!shut_alarm) begin
            sd_state <= SD_IDLE;
          end
        end
        SD_TRIPPED: begin
          // trip stays latched until software clears it with no soft or hard alarm left
          if (wr_ctrl && reg_wdata_in[CTRL_SDCLR] && !shut_alarm) begin
            sd_state <= SD_IDLE;
          end
        end
        default: begin
          sd_state <= SD_IDLE;
        end
      endcase
    end
  end

  // ===========================================
  // hardware interlock, independent of the register file
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ilk_fault_q <= 1'b0;
      ilk_trip    <= 1'b0;
    end else begin
      ilk_fault_q <= cell_ov_in | cell_uv_in | cell_ot_in | ~safety_loop_interlock_ok_in;
      if (dly[2].done) begin
        ilk_trip <= 1'b1;
      end else if (!ilk_fault_q) begin
        ilk_trip <= 1'b0;
      end
    end
  end

  // ===========================================
  // relay request and driver
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      relay_req <= '0;
      fb_en     <= '0;
    end else if (wr_ctrl) begin
      fb_en <= reg_wdata_in[CTRL_FBEN +: 2];
      // opening is always taken; new closes only with nothing pending
      if (sd_state != SD_IDLE || ilk_fault_q) begin
        relay_req <= relay_req & reg_wdata_in[CTRL_REQ +: 2];
      end else begin
        relay_req <= reg_wdata_in[CTRL_REQ +: 2];
      end
    end else if (sd_state == SD_TRIPPED || ilk_trip) begin
      relay_req <= '0;
    end
  end

  // driver drops in the cycle after any expiry
  always_comb begin
    next_drv = relay_req;
    if (sd_expired || sd_state == SD_TRIPPED) begin
      next_drv = '0;
    end
    if (dly[2].done || ilk_trip) begin
      next_drv = '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      relay_drv_out    <= '0;
      relay_enable_out <= 1'b0;
    end else begin
      relay_drv_out    <= next_drv;
      relay_enable_out <= ~(dly[2].done | ilk_trip);
    end
  end

  // ===========================================
  // position feedback supervision per relay
  generate
    for (gi = 0; gi < 2; gi++) begin : g_fb
      logic [FB_W-1:0] cnt;
      logic            mis;
      // contacts get time to follow before a mismatch counts
      assign mis = fb_en[gi] && (relay_drv_out[gi] != relay_fb_in[gi]);
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          cnt <= '0;
        end else if (!mis || relay_drv_out[gi] != next_drv[gi]) begin
          cnt <= '0;
        end else if (ms_tick && cnt <= FB_W'(FB_SETTLE_MS)) begin
          cnt <= cnt + 1'b1;
        end
      end
      assign flag_set[FL_FOPEN + gi]   = mis && cnt > FB_W'(FB_SETTLE_MS) &&
                                         relay_drv_out[gi];
      assign flag_set[FL_FCLOSED + gi] = mis && cnt > FB_W'(FB_SETTLE_MS) &&
                                         !relay_drv_out[gi];
    end
  endgenerate

  // failure flags: write one clears, a new set in the same cycle wins
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags <= '0;
    end else if (reg_wr_in && reg_addr_in == REG_FLAG) begin
      flags <= (flags & ~reg_wdata_in[3:0]) | flag_set;
    end else begin
      flags <= flags | flag_set;
    end
  end

  // ===========================================
  // software registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      alarm     <= RST_WORD[AL_W-1:0];
      gp_dir    <= RST_WORD[3:0];
      gp_out    <= RST_WORD[3:0];
      dmo_out   <= RST_WORD[1:0];
      ao1       <= RST_WORD[AO_W-1:0];
      ao2       <= RST_WORD[AO_W-1:0];
      report    <= RST_WORD[3:0];
      sens_mask <= RST_WORD[SENS_W-1:0];
      log_addr  <= RST_WORD[LOG_AW-1:0];
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        REG_ALARM:    alarm     <= reg_wdata_in[AL_W-1:0];
        REG_GP_DIR:   gp_dir    <= reg_wdata_in[3:0];
        REG_GP_OUT: begin
          gp_out  <= reg_wdata_in[3:0];
          dmo_out <= reg_wdata_in[5:4];
        end
        REG_AO1:      ao1       <= reg_wdata_in[AO_W-1:0];
        REG_AO2:      ao2       <= reg_wdata_in[AO_W-1:0];
        REG_REPORT:   report    <= reg_wdata_in[3:0];
        REG_SENS:     sens_mask <= reg_wdata_in[SENS_W-1:0];
        REG_LOG_ADDR: log_addr  <= reg_wdata_in[LOG_AW-1:0];
        default: begin
        end
      endcase
    end
  end

  // ===========================================
  // log memory: histogram bins and cell serial numbers
  // held here only; saving it across power loss is the firmware's task
  always_ff @(posedge clk_sys_in) begin
    if (reg_wr_in && reg_addr_in == REG_LOG_DATA) begin
      log_mem[log_addr] <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == REG_LOG_BUMP &&
                 log_mem[log_addr] != 32'hFFFF_FFFF) begin
      log_mem[log_addr] <= log_mem[log_addr] + 32'h0000_0001;
    end
  end

  // ===========================================
  // analog option strap, taken once after reset release
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      strap_taken <= 1'b0;
      ao_mode     <= '0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      ao_mode     <= analog_mode_in;
    end
  end

  // ===========================================
  // pins and reporting outputs
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gp_io_line_oe_out           <= '0;
      dual_mode_output_oe_out     <= '0;
      dual_mode_output_1_code_out <= '0;
      dual_mode_output_2_code_out <= '0;
      alarm_status_out            <= '0;
      alarm_can_flag_out          <= 1'b0;
      alarm_uart_flag_out         <= 1'b0;
      sensor_exclude_out          <= '0;
    end else begin
      // sinking: enable pulls the load's ground low
      gp_io_line_oe_out <= gp_dir & gp_out;
      dual_mode_output_oe_out[1] <= ~ao_mode[1] & dmo_out[1];
      dual_mode_output_oe_out[0] <= ~ao_mode[0] &
                                    (dmo_out[0] | (report[RP_DIG] & alarm_any));
      dual_mode_output_1_code_out <= !ao_mode[0] ? '0 :
                                     (report[RP_ANA] && alarm_any) ? AO_FULL : ao1;
      dual_mode_output_2_code_out <= ao_mode[1] ? ao2 : '0;
      alarm_status_out    <= alarm;
      alarm_can_flag_out  <= report[RP_CAN] & alarm_any;
      alarm_uart_flag_out <= report[RP_UART] & alarm_any;
      sensor_exclude_out  <= alarm[AL_SENSOR] ? sens_mask : '0;
    end
  end
  assign gp_io_line_out = '0;

  // ===========================================
  // read path
  always_comb begin
    rd_mux = '0;
    case (reg_addr_in)
      REG_CTRL: begin
        rd_mux[CTRL_REQ +: 2]  = relay_req;
        rd_mux[CTRL_FBEN +: 2] = fb_en;
      end
      REG_ALARM: rd_mux[AL_W-1:0] = alarm;
      REG_STAT: begin
        rd_mux[ST_DRV +: 2]     = relay_drv_out;
        rd_mux[ST_FB +: 2]      = relay_fb_in;
        rd_mux[ST_CONF +: 2]    = relay_drv_out & relay_fb_in & fb_en;
        rd_mux[ST_ILKF]         = ilk_fault_q;
        rd_mux[ST_ILKT]         = ilk_trip;
        rd_mux[ST_SDPEND]       = sd_state == SD_PENDING;
        rd_mux[ST_SDTRIP]       = sd_state == SD_TRIPPED;
        rd_mux[ST_AOMODE +: 2]  = ao_mode;
      end
      REG_FLAG:     rd_mux[3:0]        = flags;
      REG_GP_DIR:   rd_mux[3:0]        = gp_dir;
      REG_GP_OUT:   rd_mux[5:0]        = {dmo_out, gp_out};
      REG_GP_IN:    rd_mux[3:0]        = ~gp_io_line_in;
      REG_AO1:      rd_mux[AO_W-1:0]   = ao1;
      REG_AO2:      rd_mux[AO_W-1:0]   = ao2;
      REG_REPORT:   rd_mux[3:0]        = report;
      REG_SENS:     rd_mux[SENS_W-1:0] = sens_mask;
      REG_LOG_ADDR: rd_mux[LOG_AW-1:0] = log_addr;
      REG_LOG_DATA: rd_mux             = log_mem[log_addr];
      default:      rd_mux             = '0;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : '0;
    end
  end

  // ===========================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  hard_open_a: assert property (dly[0].done |=> relay_drv_out == 2'b00)
    else $error("relays not open after hard delay");
  soft_open_a: assert property (dly[1].done |=> relay_drv_out == 2'b00)
    else $error("relays not open after soft delay");
  warn_only_a: assert property ((sd_state == SD_IDLE && !shut_alarm) |=> sd_state == SD_IDLE)
    else $error("shutdown started without shutdown alarm");
  ilk_gate_a: assert property (ilk_trip |-> (relay_drv_out == 2'b00 && !relay_enable_out))
    else $error("relay driven while interlock tripped");
  ilk_source_a: assert property ((cell_ov_in || cell_uv_in || cell_ot_in ||
                                  !safety_loop_interlock_ok_in) |=> ilk_fault_q)
    else $error("interlock source not seen");
  ilk_delay_a: assert property ($rose(ilk_trip) |-> $past(dly[2].done))
    else $error("interlock tripped before its delay");
  fail_flag_a: assert property ($rose(flags[FL_FOPEN]) |-> $past(relay_drv_out[0]) &&
                                 !$past(relay_fb_in[0]))
    else $error("failed-open flag without mismatch");
  gp_in_a: assert property ((reg_rd_in && reg_addr_in == REG_GP_IN) |=>
                            reg_rdata_out[3:0] == ~$past(gp_io_line_in))
    else $error("input not read active low");
  refuse_a: assert property ((wr_ctrl && sd_state != SD_IDLE) |=>
                             (relay_req & ~$past(relay_req)) == 2'b00)
    else $error("close accepted while shutdown pending");
endmodule // rlyal_top
`default_nettype wire

// File: rlyal_relay_model.sv
`timescale 1ns/10ps
`default_nettype none
// ===========================================
// relay pair with auxiliary contacts
module rlyal_relay_model (
  input  wire logic       clk_sys_in,
  input  wire logic [1:0] coil_in,
  input  wire logic [1:0] stuck_open_in,
  input  wire logic [1:0] stuck_closed_in,
  output logic      [1:0] aux_out
);
  logic [1:0] arm_d1;
  logic [1:0] arm_d2;
  // auxiliary contact lags the coil by three cycles, so no instant confirmation
  always_ff @(posedge clk_sys_in) begin
    arm_d1  <= coil_in;
    arm_d2  <= arm_d1;
    aux_out <= (arm_d2 & ~stuck_open_in) | stuck_closed_in;
  end
endmodule // rlyal_relay_model
`default_nettype wire

// File: relay_interlock_alarm_io_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module relay_interlock_alarm_io_tb_top
  import rlyal_pkg::*;
;
  localparam int MSC = 2; // short ms tick keeps the run small
  logic clk_sys_in = 1'b0;
  logic nrst_in, reg_wr_in, reg_rd_in, cell_ov_in, cell_uv_in, cell_ot_in, rd_seen;
  logic safety_loop_interlock_ok_in, relay_enable_out, alarm_can_flag_out, alarm_uart_flag_out;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, v;
  logic [1:0] relay_fb_in, relay_drv_out, analog_mode_in, dual_mode_output_oe_out;
  logic [1:0] stuck_open, stuck_closed;
  logic [3:0] gp_io_line_in, gp_io_line_out, gp_io_line_oe_out, src;
  logic [AO_W-1:0] dual_mode_output_1_code_out, dual_mode_output_2_code_out;
  logic [AL_W-1:0] alarm_status_out;
  logic [SENS_W-1:0] sensor_exclude_out;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int comparisons = 0;
  // ===========================================
  // clock, design and relays
  always #5 clk_sys_in = ~clk_sys_in;
  rlyal_top #(.MS_CYC(MSC)) rlyal_top_inst (.clk_sys_in, .nrst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cell_ov_in, .cell_uv_in,
    .cell_ot_in, .safety_loop_interlock_ok_in, .relay_fb_in, .relay_drv_out,
    .relay_enable_out, .gp_io_line_in, .gp_io_line_out, .gp_io_line_oe_out,
    .analog_mode_in, .dual_mode_output_oe_out, .dual_mode_output_1_code_out,
    .dual_mode_output_2_code_out, .alarm_status_out, .alarm_can_flag_out,
    .alarm_uart_flag_out, .sensor_exclude_out);
  rlyal_relay_model rlyal_relay_model_inst (.clk_sys_in, .coil_in(relay_drv_out),
    .stuck_open_in(stuck_open), .stuck_closed_in(stuck_closed), .aux_out(relay_fb_in));
  // ===========================================
  // compare, report and finish
  task automatic summarize();
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys_in) rd_seen <= reg_rd_in;
  always @(negedge clk_sys_in) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) num_errors++;
      else check(reg_rdata_out, exp_q.pop_front());
    end
  end
  // ===========================================
  // bus cycles and waits
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    exp_q.push_back(e);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask
  // output must hold for lo cycles, then fall before hi
  task automatic drop(input int lo, input int hi, input bit ilk);
    for (int i = 0; i < hi; i++) begin
      @(negedge clk_sys_in);
      if ((ilk ? relay_enable_out : |relay_drv_out) !== 1'b1) begin
        check(32'(i >= lo), 32'h1);
        return;
      end
    end
    check(32'h0, 32'h1);
    summarize();
  endtask
  // ===========================================
  // main sequence
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, cell_ov_in, cell_uv_in, cell_ot_in} = 6'h00;
    {reg_addr_in, reg_wdata_in, stuck_open, stuck_closed} = 44'h0;
    safety_loop_interlock_ok_in = 1'b1;
    gp_io_line_in = 4'hF; // floating lines pulled high
    analog_mode_in = 2'b10; // output 2 strapped analog
    v = $urandom(32'hB905);
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    settle(2);
    check(32'(relay_enable_out), 32'h1);
    rd(8'hFC, 32'h0);
    rd(REG_STAT, 32'h800);
    for (int k = 0; k < 4; k++) begin
      v = $urandom();
      @(posedge clk_sys_in);
      gp_io_line_in <= v[13:10];
      wr(REG_GP_DIR, 32'(v[3:0]));
      wr(REG_GP_OUT, 32'(v[9:4]));
      rd(REG_GP_IN, {28'h0, ~v[13:10]});
      settle(2);
      check(32'(gp_io_line_oe_out), 32'(v[3:0] & v[7:4]));
      check(32'(gp_io_line_out), 32'h0);
      check(32'(dual_mode_output_oe_out), 32'(v[8]));
    end
    v = $urandom();
    wr(REG_AO2, 32'(v[12:0]));
    wr(REG_AO1, 32'(v[25:13]));
    settle(2);
    check(32'(dual_mode_output_2_code_out), 32'(v[12:0]));
    check(32'(dual_mode_output_1_code_out), 32'h0);
    wr(REG_CTRL, 32'hF);
    settle(7);
    rd(REG_STAT, 32'h83F);
    wr(REG_REPORT, 32'h7);
    wr(REG_ALARM, 32'h1);
    settle(2);
    check(32'({alarm_can_flag_out, alarm_uart_flag_out}), 32'h3);
    check(32'(dual_mode_output_oe_out), 32'h1);
    check(32'(alarm_status_out), 32'h1);
    check(32'(relay_drv_out), 32'h3);
    wr(REG_SENS, 32'(v[31:16]));
    wr(REG_ALARM, 32'h10);
    settle(2);
    check(32'(sensor_exclude_out), 32'(v[31:16]));
    check(32'(relay_drv_out), 32'h3);
    wr(REG_ALARM, 32'h0);
    settle(2);
    check(32'({sensor_exclude_out, alarm_can_flag_out}), 32'h0);
    // stuck contacts: failed-open on relay 1, then failed-closed on relay 2
    stuck_open <= 2'b01;
    settle((FB_SETTLE_MS - 10) * MSC);
    rd(REG_FLAG, 32'h0);
    settle(20 * MSC);
    rd(REG_FLAG, 32'h1);
    stuck_open <= 2'b00;
    stuck_closed <= 2'b10;
    wr(REG_CTRL, 32'hD);
    wr(REG_FLAG, 32'hF);
    settle((FB_SETTLE_MS + 5) * MSC);
    rd(REG_FLAG, 32'h8);
    stuck_closed <= 2'b00;
    wr(REG_FLAG, 32'hF);
    rd(REG_FLAG, 32'h0);
    // hard shutdown refuses a new close while pending
    wr(REG_ALARM, 32'h4);
    wr(REG_CTRL, 32'hF);
    settle(2);
    check(32'(relay_drv_out), 32'h1);
    drop((HARD_DLY_MS - 1) * MSC - 10, (HARD_DLY_MS + 2) * MSC, 1'b0);
    settle(6);
    rd(REG_STAT, 32'hA00);
    wr(REG_ALARM, 32'h0);
    wr(REG_CTRL, 32'h10);
    wr(REG_CTRL, 32'h3);
    settle(2);
    check(32'(relay_drv_out), 32'h3);
    wr(REG_ALARM, 32'h2);
    // counted from the write: strobe and state register add two cycles
    drop((SOFT_DLY_MS - 1) * MSC, (SOFT_DLY_MS + 2) * MSC + 2, 1'b0);
    wr(REG_ALARM, 32'h0);
    wr(REG_CTRL, 32'h10);
    // each interlock source in turn
    for (int k = 0; k < 4; k++) begin
      src = 4'h1 << k;
      wr(REG_CTRL, 32'h3);
      settle(2);
      check(32'(relay_drv_out), 32'h3);
      @(posedge clk_sys_in);
      cell_ov_in <= src[0];
      cell_uv_in <= src[1];
      cell_ot_in <= src[2];
      safety_loop_interlock_ok_in <= ~src[3];
      drop((ILK_DLY_MS - 1) * MSC, (ILK_DLY_MS + 2) * MSC + 2, 1'b1);
      check(32'(relay_drv_out), 32'h0);
      @(posedge clk_sys_in);
      {cell_ov_in, cell_uv_in, cell_ot_in, safety_loop_interlock_ok_in} <= 4'h1;
      settle(4);
      check(32'(relay_enable_out), 32'h1);
    end
    // lifetime log word: store, bump, saturate
    wr(REG_LOG_ADDR, 32'h5);
    wr(REG_LOG_DATA, {v[31:1], 1'b0});
    rd(REG_LOG_DATA, {v[31:1], 1'b0});
    wr(REG_LOG_BUMP, 32'h0);
    rd(REG_LOG_DATA, {v[31:1], 1'b1});
    wr(REG_LOG_DATA, 32'hFFFF_FFFF);
    wr(REG_LOG_BUMP, 32'h0);
    rd(REG_LOG_DATA, 32'hFFFF_FFFF);
    // second reset with output 1 strapped analog
    @(posedge clk_sys_in);
    analog_mode_in <= 2'b01;
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    settle(2);
    rd(REG_STAT, 32'h400);
    wr(REG_AO1, 32'(v[12:0]));
    wr(REG_REPORT, 32'hC);
    wr(REG_ALARM, 32'h1);
    settle(2);
    check(32'(dual_mode_output_1_code_out), 32'(AO_FULL));
    check(32'(dual_mode_output_oe_out), 32'h0);
    wr(REG_ALARM, 32'h0);
    settle(2);
    check(32'(dual_mode_output_1_code_out), 32'(v[12:0]));
    check(32'(dual_mode_output_2_code_out), 32'h0);
    summarize();
  end
endmodule // relay_interlock_alarm_io_tb_top
`default_nettype wire
